// >>> hw/rom_retry_pkg.sv
// constants for the identifier rom, retry limit and compare-swap registers
package rom_retry_pkg;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_ROM_ACCESS   = 8'h04;
   localparam logic [7:0] OFF_RETRY_LIMITS = 8'h08;
   localparam logic [7:0] OFF_CSW_STORE    = 8'h0c;
   localparam logic [7:0] OFF_CSW_CONTROL  = 8'h14;

   // ==========================================================
   // identifier rom access fields
   localparam int ROM_CLEAR_BIT  = 31;
   localparam int ROM_GO_BIT     = 25;
   localparam int ROM_DATA_LSB   = 16;
   localparam int ROM_DATA_W     = 8;

   // ==========================================================
   // retry limit fields
   localparam int RETRY_W        = 4;
   localparam int PHYS_RESP_LSB  = 8;
   localparam int ASYNC_RESP_LSB = 4;
   localparam int ASYNC_REQ_LSB  = 0;
   localparam logic [31:0] RETRY_RESET = 32'h0000_0000;

   // ==========================================================
   // compare-swap control fields
   localparam int CSW_DONE_BIT   = 31;
   localparam int CSW_SEL_W      = 2;
   localparam logic [1:0] CSW_BUS_MANAGER_ID        = 2'h0;
   localparam logic [1:0] CSW_BANDWIDTH_AVAILABLE   = 2'h1;
   localparam logic [1:0] CSW_CHANNELS_AVAILABLE_HI = 2'h2;
   localparam logic [1:0] CSW_CHANNELS_AVAILABLE_LO = 2'h3;

   // ==========================================================
   // reset values and timing
   localparam logic [31:0] CSW_STORE_RESET = 32'h0000_0000;
   localparam logic [7:0]  ROM_DATA_RESET  = 8'h00;
   localparam logic [1:0]  BOOT_WAIT       = 2'h3;

   typedef enum logic [1:0]
   {
      ROM_IDLE  = 2'b00,
      ROM_CLEAR = 2'b01,
      ROM_FETCH = 2'b10
   } rom_state_t;

endpackage

// >>> hw/retry_attempt_unit.sv
// one retransmit attempt counter
`timescale 1ns/1ps
module retry_attempt_unit
#(
   parameter int LIMIT_W = 4
)
(
   // clock and reset
   input  wire logic               core_clk_in,
   input  wire logic               rst_in,
   // configured limit
   input  wire logic [LIMIT_W-1:0] limit_in,
   // acknowledge from the target
   input  wire logic               packet_start_in,
   input  wire logic               ack_valid_in,
   input  wire logic               ack_retry_in,
   // outcome
   output logic                    retransmit_out,
   output logic                    done_out,
   output logic                    gave_up_out
);

   initial
   begin
      if (LIMIT_W < 1)
         $error("limit width must be at least 1");
   end

   logic [LIMIT_W-1:0] attempts_r;
   logic               may_retry;

   // ==========================================================
   // attempt count
   assign may_retry = ack_retry_in && (attempts_r != limit_in);

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         attempts_r <= '0;
      else if (packet_start_in)
         attempts_r <= '0;
      else if (ack_valid_in && may_retry)
         attempts_r <= attempts_r + 1'b1;
      else if (ack_valid_in)
         attempts_r <= '0;
   end

   // ==========================================================
   // outcome: retransmit and done pulses, gave-up held until the next done
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         retransmit_out <= 1'b0;
         done_out       <= 1'b0;
         gave_up_out    <= 1'b0;
      end
      else
      begin
         retransmit_out <= ack_valid_in && may_retry && !packet_start_in;
         done_out       <= ack_valid_in && !may_retry && !packet_start_in;
         if (ack_valid_in && !may_retry && !packet_start_in)
            gave_up_out <= ack_retry_in;
      end
   end

   // ==========================================================
   // checks
   AST_RETRY_STOPS_AT_LIMIT: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      (ack_valid_in && ack_retry_in && !packet_start_in && attempts_r == limit_in)
      |=> (done_out && gave_up_out && !retransmit_out))
      else $error("retry went past its limit");

endmodule

// >>> hw/identifier_rom_access_retry_csr_regs.sv
// identifier rom access, retry limits and compare-swap store registers
//
// What this block does
// - rom access meaningful only when eeprom present
// - address clear zeroes address, self-clears
// - clear does not load byte zero
// - setting read-go starts byte read
// - read-go self-clears when byte read done
// - read byte field updated only by device
// - unused rom access bits read zero
// - dual-phase time limit reads zero
// - dual-phase cycle limit reads zero
// - physical response retry limit writable
// - async response retry limit writable
// - async request retry limit writable
// - retry bits 15-12 zero, resets zero
// - store value holds compare-swap write data
// - eeprom present flag set when detected
// - two-bit select picks compare-swap resource
// - done set on completion, cleared on write
`timescale 1ns/1ps
module identifier_rom_access_retry_csr_regs
#(
   parameter int ROM_ADDR_W = 8
)
(
   // clock and reset
   input  wire logic                  core_clk_in,
   input  wire logic                  rst_in,
   // register port
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   input  wire logic [31:0]           reg_wdata_in,
   output logic [31:0]                reg_rdata_out,
   output logic                       reg_rvalid_out,
   // serial eeprom byte fetch
   input  wire logic                  eeprom_detect_in,
   output logic                       eeprom_present_out,
   output logic                       bus_info_load_out,
   output logic                       rom_req_out,
   output logic [ROM_ADDR_W-1:0]      rom_addr_out,
   input  wire logic                  rom_ack_in,
   input  wire logic [7:0]            rom_data_in,
   // physical response retry
   input  wire logic                  phys_start_in,
   input  wire logic                  phys_ack_valid_in,
   input  wire logic                  phys_ack_retry_in,
   output logic                       phys_retransmit_out,
   output logic                       phys_done_out,
   output logic                       phys_gave_up_out,
   // async response retry
   input  wire logic                  aresp_start_in,
   input  wire logic                  aresp_ack_valid_in,
   input  wire logic                  aresp_ack_retry_in,
   output logic                       aresp_retransmit_out,
   output logic                       aresp_done_out,
   output logic                       aresp_gave_up_out,
   // async request retry
   input  wire logic                  areq_start_in,
   input  wire logic                  areq_ack_valid_in,
   input  wire logic                  areq_ack_retry_in,
   output logic                       areq_retransmit_out,
   output logic                       areq_done_out,
   output logic                       areq_gave_up_out,
   // compare-swap engine
   input  wire logic                  csw_store_load_in,
   input  wire logic [31:0]           csw_store_data_in,
   input  wire logic                  csw_finished_in,
   output logic [31:0]                csw_store_value_out,
   output logic [1:0]                 compare_swap_resource_select_out,
   output logic                       csw_start_out
);

   initial
   begin
      if (ROM_ADDR_W < 1 || ROM_ADDR_W > 16)
         $error("rom address width must be 1 to 16");
   end

   // ==========================================================
   // declarations
   logic                  detect_meta_r;
   logic                  detect_sync_r;
   logic [1:0]            boot_cnt_r;
   logic                  eeprom_present_r;
   logic                  bus_info_load_r;
   logic                  wr_rom;
   logic                  wr_retry;
   logic                  wr_csw_ctl;
   logic                  rom_address_clear_r;
   logic                  rom_byte_read_go_r;
   logic [7:0]            rom_read_byte_r;
   logic [ROM_ADDR_W-1:0] rom_addr_r;
   rom_retry_pkg::rom_state_t rom_state_r;
   rom_retry_pkg::rom_state_t rom_state_nxt;
   logic [3:0]            physical_response_retry_limit_r;
   logic [3:0]            async_response_retry_limit_r;
   logic [3:0]            async_request_retry_limit_r;
   logic [31:0]           csw_store_r;
   logic [1:0]            compare_swap_resource_select_r;
   logic                  compare_swap_complete_r;
   logic                  csw_start_r;
   logic [31:0]           rom_word;
   logic [31:0]           retry_word;
   logic [31:0]           csw_ctl_word;
   logic [31:0]           rdata_nxt;

   // ==========================================================
   // eeprom detect synchroniser and capture after reset
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         detect_meta_r <= 1'b0;
         detect_sync_r <= 1'b0;
      end
      else
      begin
         detect_meta_r <= eeprom_detect_in;
         detect_sync_r <= detect_meta_r;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         boot_cnt_r       <= 2'h0;
         eeprom_present_r <= 1'b0;
         bus_info_load_r  <= 1'b0;
      end
      else
      begin
         bus_info_load_r <= 1'b0;
         if (boot_cnt_r != rom_retry_pkg::BOOT_WAIT)
         begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
            if (boot_cnt_r == rom_retry_pkg::BOOT_WAIT - 2'h1)
            begin
               eeprom_present_r <= detect_sync_r;
               bus_info_load_r  <= detect_sync_r;
            end
         end
      end
   end

   // ==========================================================
   // write decode
   assign wr_rom     = reg_wr_in && (reg_addr_in == rom_retry_pkg::OFF_ROM_ACCESS);
   assign wr_retry   = reg_wr_in && (reg_addr_in == rom_retry_pkg::OFF_RETRY_LIMITS);
   assign wr_csw_ctl = reg_wr_in && (reg_addr_in == rom_retry_pkg::OFF_CSW_CONTROL);

   // ==========================================================
   // rom access sequencer
   always_comb
   begin
      rom_state_nxt = rom_state_r;
      unique case (rom_state_r)
         rom_retry_pkg::ROM_IDLE:
         begin
            if (rom_address_clear_r)
               rom_state_nxt = rom_retry_pkg::ROM_CLEAR;
            else if (rom_byte_read_go_r && eeprom_present_r)
               rom_state_nxt = rom_retry_pkg::ROM_FETCH;
         end
         rom_retry_pkg::ROM_CLEAR:
            rom_state_nxt = rom_retry_pkg::ROM_IDLE;
         rom_retry_pkg::ROM_FETCH:
         begin
            if (rom_ack_in)
               rom_state_nxt = rom_retry_pkg::ROM_IDLE;
         end
         default:
            rom_state_nxt = rom_retry_pkg::ROM_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rom_state_r <= rom_retry_pkg::ROM_IDLE;
      else
         rom_state_r <= rom_state_nxt;
   end

   // set/self-clear control bits; a software set wins over the clear
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rom_address_clear_r <= 1'b0;
         rom_byte_read_go_r  <= 1'b0;
      end
      else
      begin
         if (wr_rom && reg_wdata_in[rom_retry_pkg::ROM_CLEAR_BIT])
            rom_address_clear_r <= 1'b1;
         else if (rom_state_r == rom_retry_pkg::ROM_CLEAR)
            rom_address_clear_r <= 1'b0;
         if (wr_rom && reg_wdata_in[rom_retry_pkg::ROM_GO_BIT])
            rom_byte_read_go_r <= 1'b1;
         else if (rom_state_r == rom_retry_pkg::ROM_FETCH && rom_ack_in)
            rom_byte_read_go_r <= 1'b0;
         else if (rom_state_r == rom_retry_pkg::ROM_IDLE && !rom_address_clear_r
                  && !eeprom_present_r)
            rom_byte_read_go_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rom_addr_r <= '0;
      else if (rom_state_r == rom_retry_pkg::ROM_CLEAR)
         rom_addr_r <= '0;
      else if (rom_state_r == rom_retry_pkg::ROM_FETCH && rom_ack_in)
         rom_addr_r <= rom_addr_r + 1'b1;
   end

   // only a finished fetch touches the read byte
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rom_read_byte_r <= rom_retry_pkg::ROM_DATA_RESET;
      else if (rom_state_r == rom_retry_pkg::ROM_FETCH && rom_ack_in)
         rom_read_byte_r <= rom_data_in;
   end

   // ==========================================================
   // retry limits
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         physical_response_retry_limit_r <= rom_retry_pkg::RETRY_RESET[11:8];
         async_response_retry_limit_r    <= rom_retry_pkg::RETRY_RESET[7:4];
         async_request_retry_limit_r     <= rom_retry_pkg::RETRY_RESET[3:0];
      end
      else if (wr_retry)
      begin
         physical_response_retry_limit_r <=
            reg_wdata_in[rom_retry_pkg::PHYS_RESP_LSB +: rom_retry_pkg::RETRY_W];
         async_response_retry_limit_r <=
            reg_wdata_in[rom_retry_pkg::ASYNC_RESP_LSB +: rom_retry_pkg::RETRY_W];
         async_request_retry_limit_r <=
            reg_wdata_in[rom_retry_pkg::ASYNC_REQ_LSB +: rom_retry_pkg::RETRY_W];
      end
   end

   retry_attempt_unit #(.LIMIT_W(rom_retry_pkg::RETRY_W)) phys_retry
   (
      .core_clk_in     (core_clk_in),
      .rst_in          (rst_in),
      .limit_in        (physical_response_retry_limit_r),
      .packet_start_in (phys_start_in),
      .ack_valid_in    (phys_ack_valid_in),
      .ack_retry_in    (phys_ack_retry_in),
      .retransmit_out  (phys_retransmit_out),
      .done_out        (phys_done_out),
      .gave_up_out     (phys_gave_up_out)
   );

   retry_attempt_unit #(.LIMIT_W(rom_retry_pkg::RETRY_W)) aresp_retry
   (
      .core_clk_in     (core_clk_in),
      .rst_in          (rst_in),
      .limit_in        (async_response_retry_limit_r),
      .packet_start_in (aresp_start_in),
      .ack_valid_in    (aresp_ack_valid_in),
      .ack_retry_in    (aresp_ack_retry_in),
      .retransmit_out  (aresp_retransmit_out),
      .done_out        (aresp_done_out),
      .gave_up_out     (aresp_gave_up_out)
   );

   retry_attempt_unit #(.LIMIT_W(rom_retry_pkg::RETRY_W)) areq_retry
   (
      .core_clk_in     (core_clk_in),
      .rst_in          (rst_in),
      .limit_in        (async_request_retry_limit_r),
      .packet_start_in (areq_start_in),
      .ack_valid_in    (areq_ack_valid_in),
      .ack_retry_in    (areq_ack_retry_in),
      .retransmit_out  (areq_retransmit_out),
      .done_out        (areq_done_out),
      .gave_up_out     (areq_gave_up_out)
   );

   // ==========================================================
   // compare-swap store value and control
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         csw_store_r <= rom_retry_pkg::CSW_STORE_RESET;
      else if (csw_store_load_in)
         csw_store_r <= csw_store_data_in;
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         compare_swap_resource_select_r <= rom_retry_pkg::CSW_BUS_MANAGER_ID;
         compare_swap_complete_r        <= 1'b1;
         csw_start_r                    <= 1'b0;
      end
      else
      begin
         csw_start_r <= wr_csw_ctl;
         if (wr_csw_ctl)
            compare_swap_resource_select_r <= reg_wdata_in[1:0];
         if (csw_finished_in)
            compare_swap_complete_r <= 1'b1;
         else if (wr_csw_ctl)
            compare_swap_complete_r <= 1'b0;
      end
   end

   // ==========================================================
   // read data
   always_comb
   begin
      rom_word = 32'h0000_0000;
      rom_word[rom_retry_pkg::ROM_CLEAR_BIT] = rom_address_clear_r;
      rom_word[rom_retry_pkg::ROM_GO_BIT]    = rom_byte_read_go_r;
      rom_word[rom_retry_pkg::ROM_DATA_LSB +: rom_retry_pkg::ROM_DATA_W] = rom_read_byte_r;
      retry_word = 32'h0000_0000;
      retry_word[rom_retry_pkg::PHYS_RESP_LSB +: rom_retry_pkg::RETRY_W] =
         physical_response_retry_limit_r;
      retry_word[rom_retry_pkg::ASYNC_RESP_LSB +: rom_retry_pkg::RETRY_W] =
         async_response_retry_limit_r;
      retry_word[rom_retry_pkg::ASYNC_REQ_LSB +: rom_retry_pkg::RETRY_W] =
         async_request_retry_limit_r;
      csw_ctl_word = 32'h0000_0000;
      csw_ctl_word[rom_retry_pkg::CSW_DONE_BIT] = compare_swap_complete_r;
      csw_ctl_word[1:0] = compare_swap_resource_select_r;
      unique case (reg_addr_in)
         rom_retry_pkg::OFF_ROM_ACCESS:   rdata_nxt = rom_word;
         rom_retry_pkg::OFF_RETRY_LIMITS: rdata_nxt = retry_word;
         rom_retry_pkg::OFF_CSW_STORE:    rdata_nxt = csw_store_r;
         rom_retry_pkg::OFF_CSW_CONTROL:  rdata_nxt = csw_ctl_word;
         default:                         rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         reg_rdata_out  <= 32'h0000_0000;
         reg_rvalid_out <= 1'b0;
      end
      else
      begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in)
            reg_rdata_out <= rdata_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign eeprom_present_out               = eeprom_present_r;
   assign bus_info_load_out                = bus_info_load_r;
   assign rom_req_out                      = (rom_state_r == rom_retry_pkg::ROM_FETCH);
   assign rom_addr_out                     = rom_addr_r;
   assign csw_store_value_out              = csw_store_r;
   assign compare_swap_resource_select_out = compare_swap_resource_select_r;
   assign csw_start_out                    = csw_start_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   AST_CLEAR_ZEROES_ADDR: assert property (
      (rom_state_r == rom_retry_pkg::ROM_CLEAR) |=> (rom_addr_r == '0 && !rom_address_clear_r
                                                   || $past(wr_rom)))
      else $error("address clear did not zero the address");
   AST_CLEAR_KEEPS_BYTE: assert property (
      (rom_state_r == rom_retry_pkg::ROM_CLEAR) |=> $stable(rom_read_byte_r))
      else $error("address clear changed the read byte");
   AST_GO_STARTS_FETCH: assert property (
      (rom_state_r == rom_retry_pkg::ROM_IDLE && rom_byte_read_go_r && !rom_address_clear_r
       && eeprom_present_r) |=> rom_req_out)
      else $error("read go did not start a fetch");
   AST_GO_SELF_CLEARS: assert property (
      (rom_req_out && rom_ack_in && !wr_rom) |=> (!rom_byte_read_go_r && !rom_req_out))
      else $error("read go not cleared after fetch");
   AST_BYTE_ONLY_ON_ACK: assert property (
      !(rom_req_out && rom_ack_in) |=> $stable(rom_read_byte_r))
      else $error("read byte changed without a fetch");
   AST_ROM_RESERVED_ZERO: assert property (
      reg_rd_in && reg_addr_in == rom_retry_pkg::OFF_ROM_ACCESS
      |=> (reg_rdata_out[30:26] == 5'h00 && !reg_rdata_out[24] && reg_rdata_out[15:0] == 16'h0))
      else $error("rom access reserved bits not zero");
   AST_RETRY_HIGH_ZERO: assert property (
      reg_rd_in && reg_addr_in == rom_retry_pkg::OFF_RETRY_LIMITS
      |=> (reg_rdata_out[31:12] == 20'h00000))
      else $error("retry upper bits not zero");
   AST_RETRY_WRITE_READBACK: assert property (
      wr_retry ##1 (reg_rd_in && reg_addr_in == rom_retry_pkg::OFF_RETRY_LIMITS && !wr_retry)
      |=> (reg_rdata_out[11:0] == $past(reg_wdata_in[11:0], 2)))
      else $error("retry limits did not read back");
   AST_ADDR_ADVANCES: assert property (
      (rom_req_out && rom_ack_in) |=> (rom_addr_r == $past(rom_addr_r) + 1'b1))
      else $error("rom address did not advance");
   AST_DONE_CLEARED_BY_WRITE: assert property (
      (wr_csw_ctl && !csw_finished_in) |=> (!compare_swap_complete_r && csw_start_out))
      else $error("control write did not clear done");
   AST_STORE_LOADS: assert property (
      csw_store_load_in |=> (csw_store_value_out == $past(csw_store_data_in)))
      else $error("store value not loaded");

   COV_ROM_FETCH: cover property (rom_req_out ##[1:20] rom_ack_in);
   COV_ADDR_CLEAR: cover property (rom_state_r == rom_retry_pkg::ROM_CLEAR);
   COV_CSW_DONE: cover property (wr_csw_ctl ##[1:50] csw_finished_in);
   COV_PHYS_GIVE_UP: cover property (phys_done_out && phys_gave_up_out);

endmodule

// >>> verification/rom_model.sv
// serial eeprom byte fetch model
`timescale 1ns/1ps
module rom_model
#(
   parameter int DELAY = 2
)
(
   // fetch handshake
   input  wire logic       core_clk_in,
   input  wire logic       req_in,
   input  wire logic [7:0] addr_in,
   output logic            ack_out,
   output logic [7:0]      data_out
);
   int cnt = 0;
   initial ack_out = 1'b0;
   initial data_out = 8'h00;
   // ==========
   // answer a fetch after DELAY cycles
   always @(posedge core_clk_in)
   begin
      if (ack_out || !req_in)
      begin
         ack_out <= 1'b0;
         data_out <= ~data_out;
         cnt = 0;
      end
      else if (cnt == DELAY)
      begin
         ack_out <= 1'b1;
         data_out <= addr_in ^ 8'ha5;
      end
      else
         cnt++;
   end
endmodule

// >>> verification/identifier_rom_access_retry_csr_regs_tb.sv
// testbench for the rom, retry and compare-swap registers
`timescale 1ns/1ps
module identifier_rom_access_retry_csr_regs_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic        wr = 1'b0;
   logic [4:0]  stb = 5'h00;
   localparam int RD_I = 0, AV_I = 1, LD_I = 2, ST_I = 3, FIN_I = 4;
   wire         rd = stb[0];
   wire         av = stb[1];
   wire         ld = stb[2];
   wire         start = stb[3];
   wire         fin = stb[4];
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic        rvalid;
   logic        present;
   logic        req;
   logic [7:0]  raddr;
   logic        ack;
   logic [7:0]  rbyte;
   logic        det = 1'b1;
   logic        ar = 1'b1;
   logic        bil;
   logic [31:0] sv;
   int          loads = 0;
   logic [2:0]  rt;
   logic [2:0]  dn;
   logic [2:0]  gu;
   logic [1:0]  sel;
   logic        cst;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   always #4 clk = ~clk;
   rom_model #(.DELAY(3)) model (.core_clk_in(clk), .req_in(req), .addr_in(raddr),
      .ack_out(ack), .data_out(rbyte));
   identifier_rom_access_retry_csr_regs DUT (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .eeprom_detect_in(det), .eeprom_present_out(present),
      .bus_info_load_out(bil), .rom_req_out(req), .rom_addr_out(raddr), .rom_ack_in(ack),
      .rom_data_in(rbyte), .phys_start_in(start), .phys_ack_valid_in(av),
      .phys_ack_retry_in(ar), .phys_retransmit_out(rt[2]), .phys_done_out(dn[2]),
      .phys_gave_up_out(gu[2]), .aresp_start_in(start), .aresp_ack_valid_in(av),
      .aresp_ack_retry_in(ar), .aresp_retransmit_out(rt[1]), .aresp_done_out(dn[1]),
      .aresp_gave_up_out(gu[1]), .areq_start_in(start), .areq_ack_valid_in(av),
      .areq_ack_retry_in(ar), .areq_retransmit_out(rt[0]), .areq_done_out(dn[0]),
      .areq_gave_up_out(gu[0]), .csw_store_load_in(ld), .csw_store_data_in(wd),
      .csw_finished_in(fin), .csw_store_value_out(sv),
      .compare_swap_resource_select_out(sel), .csw_start_out(cst));
   // ==========
   // shared tasks
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      stb <= 5'h01 << i;
      @(posedge clk);
      stb <= 5'h00;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      stb <= 5'h01;
      @(posedge clk);
      stb <= 5'h00;
      #1;
      chk("rvalid", 32'h1, {31'h0, rvalid});
      d = rdata;
   endtask
   task automatic rom_op(input int b, input logic [31:0] e);
      logic [31:0] d;
      wr_reg(8'h04, 32'h1 << b);
      repeat (20)
      begin
         rd_reg(8'h04, d);
         if (d[b] === 1'b0)
            break;
      end
      chk("rom access", e, d);
   endtask
   task automatic ack_step(input logic [2:0] m, input logic [2:0] er, input logic [2:0] ed);
      pulse(AV_I);
      #1;
      chk("retransmit", {29'h0, er}, {29'h0, rt & m});
      chk("done", {29'h0, ed}, {29'h0, dn & m});
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (bil === 1'b1)
         loads++;
      if (cycles == 5000)
      begin
         fail_count++;
         complete_run();
      end
   end
   // ==========
   // scenarios
   initial
   begin
      logic [31:0] d;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("present", 32'h1, {31'h0, present});
      rd_reg(8'h08, d);
      chk("retry reset", 32'h0, d);
      wr_reg(8'h08, 32'hffff_ffff);
      rd_reg(8'h08, d);
      chk("retry mask", 32'h0000_0fff, d);
      rom_op(rom_retry_pkg::ROM_GO_BIT, 32'h00a5_0000);
      rom_op(rom_retry_pkg::ROM_GO_BIT, 32'h00a4_0000);
      rom_op(rom_retry_pkg::ROM_CLEAR_BIT, 32'h00a4_0000);
      rom_op(rom_retry_pkg::ROM_GO_BIT, 32'h00a5_0000);
      @(posedge clk);
      wd <= 32'h5a3c_0f96;
      pulse(LD_I);
      #1;
      chk("store out", 32'h5a3c_0f96, sv);
      wr_reg(8'h0c, 32'h0);
      rd_reg(8'h0c, d);
      chk("store", 32'h5a3c_0f96, d);
      wr_reg(8'h08, 32'h0000_0210);
      pulse(ST_I);
      ack_step(3'b111, 3'b110, 3'b001);
      ack_step(3'b110, 3'b100, 3'b010);
      ack_step(3'b100, 3'b000, 3'b100);
      chk("gave up", 32'h7, {29'h0, gu});
      @(posedge clk);
      ar <= 1'b0;
      ack_step(3'b111, 3'b000, 3'b111);
      chk("gave up clear", 32'h0, {29'h0, gu});
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(8'h14, i);
         #1;
         chk("start", 32'h1, {31'h0, cst});
         repeat (3) @(posedge clk);
         chk("select", i, {30'h0, sel});
         rd_reg(8'h14, d);
         chk("control", i, d);
      end
      pulse(FIN_I);
      rd_reg(8'h14, d);
      chk("done set", 32'h8000_0003, d);
      rd_reg(8'h40, d);
      chk("unmapped", 32'h0, d);
      chk("boot loads", 32'h1, loads);
      @(posedge clk);
      rst <= 1'b1;
      det <= 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("absent", 32'h0, {31'h0, present});
      rom_op(rom_retry_pkg::ROM_GO_BIT, 32'h0000_0000);
      chk("rom addr", 32'h0, {24'h0, raddr});
      chk("absent loads", 32'h1, loads);
      complete_run();
   end
endmodule
